// ---- core/battery_monitor_pkg.sv ----
// Package with constants, types and states for the battery monitor serial slave.
package battery_monitor_pkg;
  // ****************************************
  // Register map and field layout
  // ****************************************
  localparam logic [7:0] CFG_OFFSET = 8'h01;
  localparam logic [7:0] TOP_ADDR = 8'hFF;
  localparam logic [7:0] PAST_TOP_DATA = 8'hFF;
  localparam logic [7:0] UNMAPPED_DATA = 8'h00;
  localparam logic [7:0] CFG_RESET = 8'h40;
  localparam int PIN_BIT = 3;
  localparam int POF_BIT = 6;
  localparam logic [3:0] ADDR_HIGH_BITS = 4'h9;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  // ****************************************
  // Timing and current blanking
  // ****************************************
  localparam longint CLK_HZ = 125000000;
  localparam longint SLEEP_TIME_MS = 2000;
  localparam longint SLEEP_CYCLES_DEF = SLEEP_TIME_MS * (CLK_HZ / 1000);
  localparam int SLEEP_CNT_W = 28;
  localparam longint NEG_BLANK_UV = 25;
  localparam longint CUR_LSB_PV = 1562500;
  localparam logic [15:0] NEG_BLANK_LSB = 16'((NEG_BLANK_UV * 1000000) / CUR_LSB_PV);
  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic reserved;
    logic power_on_flag;
    logic sleep_allow;
    logic negative_blank_enable;
    logic open_drain_pin_bit;
    logic [2:0] slave_addr_low_bits;
  } status_config_t;
  typedef enum {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_MEMORY_ADDRESS_BYTE, ST_WDATA, ST_BYTE_ACK, ST_RDATA, ST_MASTER_ACK
  } link_state_t;
endpackage : battery_monitor_pkg

// ---- core/battery_monitor_i2c_slave_config.sv ----
// Two-wire slave interface and status/config register of a battery monitor.
// Operation
// R1: Power-on flag set at reset, cleared only by zero
// R2: Sleep after both lines low two seconds
// R3: Blank small negative currents when enabled
// R4: Pin bit zero drives pin low, one releases
// R5: Pin bit reads actual pin level
// R6: Low address bits programmable, used after start
// R7: Seven-bit slave only, any rate to 400kHz
// R8: Data line input receiving, open-drain when sending
// R9: One bit per clock, data stable clock high
// R10: Master frames transactions with start and stop
// R11: Repeated start ends transaction, begins new one
// R12: Acknowledge pulls data low on ninth clock
// R13: No-acknowledge leaves data released on ninth clock
// R14: Master retries failed transfers
// R15: Bytes sent msb first, acknowledge follows lsb
// R16: Multi-byte values most significant byte first
// R17: Acknowledge matching address after direction bit
// R18: Direction bit selects write or read
// R19: Master drives clock, stop returns idle
// R20: Write address increments, ignored past top or unmapped
// R21: Read address increments, past top returns FFh
// R22: Master ends read with no-acknowledge then stop
// R23: Read byte latched for the whole transfer
// R24: Reserved top bit ignores writes, reads zero
`timescale 1ns/1ps
module battery_monitor_i2c_slave_config
  import battery_monitor_pkg::*;
#(
  parameter longint SLEEP_CYCLES = SLEEP_CYCLES_DEF
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic link_clk,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic pio_i,
  output logic pio_o,
  output logic pio_oe,
  input wire logic [15:0] cur_sample,
  input wire logic cur_valid,
  output logic [15:0] cur_blanked,
  output logic cur_blanked_valid,
  output logic sleep_mode
);
  // ****************************************
  // Link domain: reset and pin synchronisers
  // ****************************************
  logic [1:0] lrst_sync;
  logic [1:0] scl_l_sync;
  logic [1:0] sda_l_sync;
  logic [1:0] pio_sync;
  logic link_rst;
  logic scl_s;
  logic sda_s;
  logic scl_prev_reg;
  logic sda_prev_reg;
  always_ff @(posedge link_clk) begin
    lrst_sync <= {lrst_sync[0], reset};
    scl_l_sync <= {scl_l_sync[0], scl_i};
    sda_l_sync <= {sda_l_sync[0], sda_i};
    pio_sync <= {pio_sync[0], pio_i};
    scl_prev_reg <= scl_s;
    sda_prev_reg <= sda_s;
  end
  assign link_rst = lrst_sync[1];
  assign scl_s = scl_l_sync[1];
  assign sda_s = sda_l_sync[1];
  wire scl_rise = scl_s && !scl_prev_reg;
  wire scl_fall = !scl_s && scl_prev_reg;
  wire start_det = scl_s && scl_prev_reg && sda_prev_reg && !sda_s;
  wire stop_det = scl_s && scl_prev_reg && !sda_prev_reg && sda_s;
  // ****************************************
  // Status/config register and read mux
  // ****************************************
  status_config_t cfg_reg;
  status_config_t wr_fields;
  link_state_t state_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] tx_reg;
  logic [7:0] ptr_reg;
  logic past_top_reg;
  logic rw_reg;
  logic nack_reg;
  logic [2:0] addr_active_reg;
  logic sda_oe_reg;
  logic pio_oe_reg;
  assign wr_fields = status_config_t'(shift_reg);
  wire byte_done = scl_fall && (bit_cnt_reg == BYTE_BITS);
  wire addr_match = (shift_reg[7:1] == {ADDR_HIGH_BITS, addr_active_reg});
  wire cfg_write = (state_reg == ST_WDATA) && byte_done && !past_top_reg
    && (ptr_reg == CFG_OFFSET);
  wire [7:0] cfg_read = {1'b0, cfg_reg.power_on_flag, cfg_reg.sleep_allow,
    cfg_reg.negative_blank_enable, pio_sync[1], cfg_reg.slave_addr_low_bits}; // R5
  wire [7:0] read_value = past_top_reg ? PAST_TOP_DATA :
    (ptr_reg == CFG_OFFSET) ? cfg_read : UNMAPPED_DATA;
  wire [7:0] ptr_inc = ptr_reg + 8'h01;
  wire ptr_wrap = (ptr_reg == TOP_ADDR);
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      cfg_reg <= status_config_t'(CFG_RESET); // R1 R5
      pio_oe_reg <= 1'b1;
    end else begin
      if (cfg_write) begin
        cfg_reg.reserved <= 1'b0; // R24
        cfg_reg.power_on_flag <= cfg_reg.power_on_flag & wr_fields.power_on_flag; // R1
        cfg_reg.sleep_allow <= wr_fields.sleep_allow;
        cfg_reg.negative_blank_enable <= wr_fields.negative_blank_enable;
        cfg_reg.open_drain_pin_bit <= wr_fields.open_drain_pin_bit;
        cfg_reg.slave_addr_low_bits <= wr_fields.slave_addr_low_bits; // R6
      end
      pio_oe_reg <= !cfg_reg.open_drain_pin_bit; // R4
    end
  end
  // ****************************************
  // Serial engine
  // ****************************************
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      state_reg <= ST_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      tx_reg <= 8'h00;
      ptr_reg <= 8'h00;
      past_top_reg <= 1'b0;
      rw_reg <= 1'b0;
      nack_reg <= 1'b0;
      addr_active_reg <= 3'h0;
      sda_oe_reg <= 1'b0;
    end else if (start_det) begin
      state_reg <= ST_ADDR; // R11
      bit_cnt_reg <= 4'h0;
      sda_oe_reg <= 1'b0;
      addr_active_reg <= cfg_reg.slave_addr_low_bits; // R6
    end else if (stop_det) begin
      state_reg <= ST_IDLE; // R19
      sda_oe_reg <= 1'b0;
    end else begin
      if (scl_rise && state_reg != ST_RDATA) begin
        shift_reg <= {shift_reg[6:0], sda_s}; // R15
      end
      if (scl_rise) begin
        bit_cnt_reg <= bit_cnt_reg + 4'h1; // R9
      end
      case (state_reg)
        ST_ADDR: begin
          if (byte_done) begin
            if (addr_match) begin
              sda_oe_reg <= 1'b1; // R17 R12
              rw_reg <= shift_reg[0]; // R18
              state_reg <= ST_ADDR_ACK;
            end else begin
              state_reg <= ST_IDLE; // R7
            end
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            bit_cnt_reg <= 4'h0;
            if (rw_reg) begin
              tx_reg <= read_value; // R23
              sda_oe_reg <= !read_value[7]; // R8
              state_reg <= ST_RDATA;
            end else begin
              sda_oe_reg <= 1'b0;
              state_reg <= ST_MEMORY_ADDRESS_BYTE;
            end
          end
        end
        ST_MEMORY_ADDRESS_BYTE: begin
          if (byte_done) begin
            ptr_reg <= shift_reg;
            past_top_reg <= 1'b0;
            sda_oe_reg <= 1'b1; // R12
            state_reg <= ST_BYTE_ACK;
          end
        end
        ST_WDATA: begin
          if (byte_done) begin
            ptr_reg <= ptr_inc; // R20
            past_top_reg <= past_top_reg | ptr_wrap; // R20
            sda_oe_reg <= 1'b1;
            state_reg <= ST_BYTE_ACK;
          end
        end
        ST_BYTE_ACK: begin
          if (scl_fall) begin
            bit_cnt_reg <= 4'h0;
            sda_oe_reg <= 1'b0;
            state_reg <= ST_WDATA;
          end
        end
        ST_RDATA: begin
          if (byte_done) begin
            sda_oe_reg <= 1'b0;
            ptr_reg <= ptr_inc; // R21
            past_top_reg <= past_top_reg | ptr_wrap; // R21
            state_reg <= ST_MASTER_ACK;
          end else if (scl_fall) begin
            tx_reg <= {tx_reg[6:0], 1'b0};
            sda_oe_reg <= !tx_reg[6]; // R15 R9
          end
        end
        ST_MASTER_ACK: begin
          if (scl_rise) begin
            nack_reg <= sda_s; // R13
          end
          if (scl_fall) begin
            bit_cnt_reg <= 4'h0;
            if (nack_reg) begin
              state_reg <= ST_IDLE; // R22
            end else begin
              tx_reg <= read_value; // R16 R23
              sda_oe_reg <= !read_value[7];
              state_reg <= ST_RDATA;
            end
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end
  assign sda_oe = sda_oe_reg;
  assign sda_o = 1'b0;
  assign pio_oe = pio_oe_reg;
  assign pio_o = 1'b0;
  // ****************************************
  // Reference domain: sleep timer and blanking
  // ****************************************
  logic [1:0] scl_r_sync;
  logic [1:0] sda_r_sync;
  logic [1:0] sleep_allow_sync;
  logic [1:0] nblank_sync;
  logic [SLEEP_CNT_W-1:0] low_cnt_reg;
  logic sleep_mode_reg;
  logic [15:0] cur_blanked_reg;
  logic cur_valid_reg;
  always_ff @(posedge ref_clk) begin
    scl_r_sync <= {scl_r_sync[0], scl_i};
    sda_r_sync <= {sda_r_sync[0], sda_i};
    sleep_allow_sync <= {sleep_allow_sync[0], cfg_reg.sleep_allow};
    nblank_sync <= {nblank_sync[0], cfg_reg.negative_blank_enable};
  end
  wire lines_low = !scl_r_sync[1] && !sda_r_sync[1];
  wire sleep_due = (low_cnt_reg == SLEEP_CNT_W'(SLEEP_CYCLES - 1));
  wire [15:0] neg_mag = 16'h0000 - cur_sample;
  wire blank_hit = nblank_sync[1] && cur_sample[15] && (neg_mag <= NEG_BLANK_LSB);
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      low_cnt_reg <= '0;
      sleep_mode_reg <= 1'b0;
      cur_blanked_reg <= 16'h0000;
      cur_valid_reg <= 1'b0;
    end else begin
      if (!lines_low || !sleep_allow_sync[1]) begin
        low_cnt_reg <= '0;
      end else if (!sleep_due) begin
        low_cnt_reg <= low_cnt_reg + SLEEP_CNT_W'(1);
      end
      sleep_mode_reg <= lines_low && sleep_allow_sync[1] && (sleep_due || sleep_mode_reg); // R2
      cur_valid_reg <= cur_valid;
      if (cur_valid) begin
        cur_blanked_reg <= blank_hit ? 16'h0000 : cur_sample; // R3
      end
    end
  end
  assign sleep_mode = sleep_mode_reg;
  assign cur_blanked = cur_blanked_reg;
  assign cur_blanked_valid = cur_valid_reg;
  // ****************************************
  // Assertions
  // ****************************************
  sequence addr_byte_matched;
    state_reg == ST_ADDR && byte_done && addr_match && !start_det && !stop_det;
  endsequence
  sequence write_pin_low;
    cfg_write && !shift_reg[PIN_BIT];
  endsequence
  chk_pof_never_sets: assert property (@(posedge link_clk) disable iff (link_rst) // R1
    !$rose(cfg_reg.power_on_flag)) else $error("Power-on flag set by itself.");
  chk_sleep_entry_time: assert property (@(posedge ref_clk) disable iff (reset) // R2
    lines_low && sleep_allow_sync[1] && sleep_due |=> sleep_mode_reg)
    else $error("Sleep not entered after low period.");
  chk_negative_blanking: assert property (@(posedge ref_clk) disable iff (reset) // R3
    cur_valid && blank_hit |=> cur_blanked_valid && cur_blanked == 16'h0000)
    else $error("Small negative current not blanked.");
  chk_pin_drive_low: assert property (@(posedge link_clk) disable iff (link_rst) // R4
    write_pin_low |=> ##1 pio_oe) else $error("Pin not driven low after write.");
  chk_pin_readback: assert property (@(posedge link_clk) disable iff (link_rst) // R5
    pio_oe_reg && $past(pio_oe_reg) && $past(pio_oe_reg, 2) |-> !cfg_read[PIN_BIT])
    else $error("Pin bit does not show pin level.");
  chk_addr_ack_drive: assert property (@(posedge link_clk) disable iff (link_rst) // R17
    addr_byte_matched |=> sda_oe_reg && state_reg == ST_ADDR_ACK)
    else $error("Matching address not acknowledged.");
  chk_start_restarts: assert property (@(posedge link_clk) disable iff (link_rst) // R11
    start_det |=> state_reg == ST_ADDR && bit_cnt_reg == 4'h0 && !sda_oe_reg)
    else $error("Start did not restart address phase.");
  chk_stop_to_idle: assert property (@(posedge link_clk) disable iff (link_rst) // R19
    stop_det |=> state_reg == ST_IDLE && !sda_oe_reg) else $error("Stop did not idle.");
  chk_sda_stable_high: assert property (@(posedge link_clk) disable iff (link_rst) // R9
    $changed(sda_oe_reg) |-> !scl_s || $past(start_det) || $past(stop_det))
    else $error("Data line changed while clock high.");
  chk_write_ptr_adv: assert property (@(posedge link_clk) disable iff (link_rst) // R20
    state_reg == ST_WDATA && byte_done && !start_det && !stop_det
    |=> ptr_reg == $past(ptr_inc)) else $error("Write pointer did not advance.");
  chk_reserved_zero: assert property (@(posedge link_clk) disable iff (link_rst) // R24
    !cfg_read[7] && !cfg_reg.reserved) else $error("Reserved bit not zero.");
endmodule : battery_monitor_i2c_slave_config

// ---- testbench/bus_master_model.sv ----
// Behavioural two-wire bus master that drives clock and data as open-drain pulls.
`timescale 1ns/1ps
module bus_master_model (
  input wire logic sda_line,
  output logic scl_low,
  output logic sda_low
);
  localparam int HALF = 60;
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  // ****************************************
  // Bus conditions and bits
  // ****************************************
  // Data is released with clock low first, so the same task also makes a repeated start.
  task automatic start_bit();
    #(HALF / 2) sda_low = 1'b0;
    #(HALF / 2) scl_low = 1'b0;
    #HALF sda_low = 1'b1;
    #HALF scl_low = 1'b1;
  endtask : start_bit
  task automatic stop_bit();
    #(HALF / 2) sda_low = 1'b1;
    #(HALF / 2) scl_low = 1'b0;
    #HALF sda_low = 1'b0;
    #HALF;
  endtask : stop_bit
  task automatic clock_bit(input logic b, output logic s);
    #(HALF / 2) sda_low = ~b;
    #(HALF / 2) scl_low = 1'b0;
    #HALF s = sda_line;
    scl_low = 1'b1;
  endtask : clock_bit
  task automatic write_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) clock_bit(b[i], s);
    clock_bit(1'b1, ack);
  endtask : write_byte
  task automatic read_byte(output logic [7:0] b, input logic last);
    logic s;
    for (int i = 7; i >= 0; i--) clock_bit(1'b1, b[i]);
    clock_bit(last, s);
  endtask : read_byte
endmodule : bus_master_model

// ---- testbench/tb.sv ----
// Self-checking bench for the battery monitor serial slave and its config register.
`timescale 1ns/1ps
module tb
  import battery_monitor_pkg::*;
();
  localparam longint SLEEP_N = 50;
  logic ref_clk = 1'b0;
  logic link_clk = 1'b0;
  logic reset = 1'b1;
  logic pin_ext_low = 1'b0;
  logic cur_valid = 1'b0;
  logic [15:0] cur_sample = 16'h0000;
  logic [15:0] cur_blanked;
  logic cur_blanked_valid, sleep_mode, sda_o, sda_oe, pio_o, pio_oe, m_scl_low, m_sda_low, a;
  logic [23:0] q;
  int n_errors = 0;
  int tests_run = 0;
  wire logic scl_line = ~m_scl_low;
  wire logic sda_line = ~(m_sda_low | sda_oe);
  wire logic pin_line = ~(pio_oe | pin_ext_low);
  battery_monitor_i2c_slave_config #(.SLEEP_CYCLES(SLEEP_N)) u_battery_monitor_i2c_slave_config (
    .ref_clk(ref_clk), .reset(reset), .link_clk(link_clk), .scl_i(scl_line), .sda_i(sda_line),
    .sda_o(sda_o), .sda_oe(sda_oe), .pio_i(pin_line), .pio_o(pio_o), .pio_oe(pio_oe),
    .cur_sample(cur_sample), .cur_valid(cur_valid), .cur_blanked(cur_blanked),
    .cur_blanked_valid(cur_blanked_valid), .sleep_mode(sleep_mode));
  bus_master_model u_bus_master_model (.sda_line(sda_line), .scl_low(m_scl_low),
    .sda_low(m_sda_low));
  initial forever #4 ref_clk = ~ref_clk;
  initial begin
    #1.7;
    forever #3 link_clk = ~link_clk;
  end
  // ****************************************
  // Compare, report and bus tasks
  // ****************************************
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_word
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    chk_word({8'h00, got}, {8'h00, exp});
  endtask : chk_byte
  task automatic chk_bit(input logic got, input logic exp);
    chk_word({15'h0000, got}, {15'h0000, exp});
  endtask : chk_bit
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : close_out
  task automatic wr(input logic [6:0] sa, input logic [7:0] ma, input logic [23:0] d, input int n);
    logic k;
    u_bus_master_model.start_bit();
    u_bus_master_model.write_byte({sa, 1'b0}, k);
    chk_bit(k, 1'b0);
    u_bus_master_model.write_byte(ma, k);
    chk_bit(k, 1'b0);
    for (int i = n; i > 0; i--) begin
      u_bus_master_model.write_byte(d[i * 8 - 1 -: 8], k);
      chk_bit(k, 1'b0);
    end
    u_bus_master_model.stop_bit();
  endtask : wr
  task automatic rd(input logic [6:0] sa, input logic [7:0] ma, input int n,
    output logic [23:0] r);
    logic k;
    logic [7:0] b;
    r = 24'h000000;
    u_bus_master_model.start_bit();
    u_bus_master_model.write_byte({sa, 1'b0}, k);
    chk_bit(k, 1'b0);
    u_bus_master_model.write_byte(ma, k);
    chk_bit(k, 1'b0);
    u_bus_master_model.start_bit();
    u_bus_master_model.write_byte({sa, 1'b1}, k);
    chk_bit(k, 1'b0);
    for (int i = 0; i < n; i++) begin
      u_bus_master_model.read_byte(b, i == n - 1);
      r = {r[15:0], b};
    end
    u_bus_master_model.stop_bit();
  endtask : rd
  task automatic cur(input logic [15:0] s, input logic [15:0] e);
    @(negedge ref_clk);
    cur_sample = s;
    cur_valid = 1'b1;
    @(negedge ref_clk);
    cur_valid = 1'b0;
    chk_bit(cur_blanked_valid, 1'b1);
    chk_word(cur_blanked, e);
    @(negedge ref_clk);
    chk_bit(cur_blanked_valid, 1'b0);
  endtask : cur
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic sc_reset_state();
    rd(7'h48, 8'h01, 1, q);
    chk_byte(q[7:0], CFG_RESET);
    chk_bit(pio_oe, 1'b1);
    chk_bit(pio_o, 1'b0);
    chk_bit(sda_o, 1'b0);
    chk_bit(sleep_mode, 1'b0);
  endtask : sc_reset_state
  task automatic sc_config_write();
    wr(7'h48, 8'h01, 24'h0000FF, 1);
    u_bus_master_model.start_bit();
    u_bus_master_model.write_byte({7'h48, 1'b0}, a);
    u_bus_master_model.stop_bit();
    chk_bit(a, 1'b1);
    rd(7'h4F, 8'h01, 1, q);
    chk_byte(q[7:0], 8'h7F);
    chk_bit(pio_oe, 1'b0);
    pin_ext_low = 1'b1;
    rd(7'h4F, 8'h01, 1, q);
    chk_byte(q[7:0], 8'h77);
    pin_ext_low = 1'b0;
  endtask : sc_config_write
  task automatic sc_flag_clear();
    wr(7'h4F, 8'h01, 24'h000038, 1);
    rd(7'h48, 8'h01, 1, q);
    chk_byte(q[7:0], 8'h38);
    wr(7'h48, 8'h01, 24'h000078, 1);
    rd(7'h48, 8'h01, 1, q);
    chk_byte(q[7:0], 8'h38);
  endtask : sc_flag_clear
  task automatic sc_increment();
    wr(7'h48, 8'h00, 24'h001130, 2);
    rd(7'h48, 8'h00, 3, q);
    chk_byte(q[23:16], 8'h00);
    chk_word(q[15:0], 16'h3000);
    wr(7'h48, 8'hFF, 24'h070707, 3);
    rd(7'h48, 8'hFE, 3, q);
    chk_byte(q[23:16], 8'h00);
    chk_word(q[15:0], 16'h00FF);
    rd(7'h48, 8'h01, 1, q);
    chk_byte(q[7:0], 8'h30);
  endtask : sc_increment
  task automatic sc_blanking();
    cur(16'hFFF0, 16'h0000);
    cur(16'hFFEF, 16'hFFEF);
    cur(16'hFFFF, 16'h0000);
    cur(16'h0005, 16'h0005);
    wr(7'h48, 8'h01, 24'h000020, 1);
    cur(16'hFFFF, 16'hFFFF);
  endtask : sc_blanking
  task automatic sc_sleep();
    int n;
    n = 0;
    u_bus_master_model.start_bit();
    while (sleep_mode !== 1'b1 && n < 200) begin
      @(negedge ref_clk);
      n++;
    end
    chk_bit(n >= SLEEP_N && n <= SLEEP_N + 10, 1'b1);
    if (n == 200) close_out();
    u_bus_master_model.stop_bit();
    repeat (4) @(negedge ref_clk);
    chk_bit(sleep_mode, 1'b0);
    wr(7'h48, 8'h01, 24'h000000, 1);
    u_bus_master_model.start_bit();
    repeat (SLEEP_N + 20) @(negedge ref_clk);
    chk_bit(sleep_mode, 1'b0);
    u_bus_master_model.stop_bit();
  endtask : sc_sleep
  initial begin
    #500000;
    n_errors++;
    close_out();
  end
  initial begin
    repeat (8) @(negedge ref_clk);
    reset = 1'b0;
    repeat (10) @(negedge ref_clk);
    sc_reset_state();
    sc_config_write();
    sc_flag_clear();
    sc_increment();
    sc_blanking();
    sc_sleep();
    close_out();
  end
endmodule : tb
